// ### pcint_top.sv
// pcint_top: pin change interrupt unit with register port.
// assumes a one-cycle read latency master and pins asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module pcint_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // monitored pins
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_b_pins,
    input wire logic [7:0] port_c_pins,
    input wire logic port_e_pin_three,
    // core sleep state
    input wire logic core_asleep,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // requests
    output logic change_irq_summary_flag,
    output logic change_irq_req,
    output logic wake_req,
    output logic irq
);
    typedef struct packed {
        logic [pcint_pkg::PIN_N-1:0] rise_en;
        logic [pcint_pkg::PIN_N-1:0] fall_en;
        logic [pcint_pkg::PIN_N-1:0] flags;
        logic master_en;
        logic summary;
        logic chg_req;
        logic wake;
        logic [pcint_pkg::EVT_W-1:0] evt_st;
        logic [pcint_pkg::EVT_W-1:0] evt_msk;
        logic irq;
        logic [pcint_pkg::PORT_W-1:0] rdata;
        logic [pcint_pkg::SYNC_N:0] settle;
    } pcint_st_t;

    pcint_st_t st_r;
    pcint_st_t st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [pcint_pkg::PIN_N-1:0] pins;
    logic [pcint_pkg::PIN_N-1:0] hit;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // only the documented pins are wired to detectors
    assign pins = {port_e_pin_three, port_c_pins, port_b_pins,
                   port_a_pins};

    genvar g;
    generate
        for (g = 0; g < pcint_pkg::PIN_N; g++) begin : g_pin
            pcint_edge u_edge (
                .clk(core_clk),
                .rst_n(rst_n),
                .pin(pins[g]),
                .rise_en(st_r.rise_en[g]),
                .fall_en(st_r.fall_en[g]),
                .edge_hit(hit[g])
            );
        end
    endgenerate

    function automatic logic [pcint_pkg::PIN_N-1:0] put_byte(
        input logic [pcint_pkg::PIN_N-1:0] cur,
        input logic [3:0] idx,
        input logic [pcint_pkg::PORT_W-1:0] val
    );
        logic [pcint_pkg::PIN_N-1:0] res;
        res = cur;
        case (idx)
            4'h0: res[7:0] = val;
            4'h1: res[15:8] = val;
            4'h2: res[23:16] = val;
            default: res[24] = val[pcint_pkg::PORT_E_BIT];
        endcase
        return res;
    endfunction

    function automatic logic [pcint_pkg::PORT_W-1:0] get_byte(
        input logic [pcint_pkg::PIN_N-1:0] cur,
        input logic [3:0] idx
    );
        logic [pcint_pkg::PORT_W-1:0] res;
        res = pcint_pkg::BYTE_ZERO;
        case (idx)
            4'h0: res = cur[7:0];
            4'h1: res = cur[15:8];
            4'h2: res = cur[23:16];
            default: res[pcint_pkg::PORT_E_BIT] = cur[24];
        endcase
        return res;
    endfunction

    logic [3:0] sub;
    logic [pcint_pkg::PIN_N-1:0] flags_wr;
    logic [pcint_pkg::PIN_N-1:0] flags_new;
    logic [pcint_pkg::PIN_N-1:0] hit_ok;
    logic [pcint_pkg::EVT_W-1:0] evt;
    logic summary_new;
    logic any_hit;
    logic settled;
    // one write strobe per register group
    logic wr_rise;
    logic wr_fall;
    logic wr_flag;
    logic wr_ctrl;
    logic wr_evt;
    logic wr_msk;

    assign sub = {2'h0, reg_addr[1:0]};

    // no edges until the sample history is filled after reset,
    // otherwise a pin idling high would look like a rising edge
    assign settled = st_r.settle[pcint_pkg::SYNC_N];
    assign hit_ok = hit & {pcint_pkg::PIN_N{settled}};
    assign any_hit = |hit_ok;

    // port registers take four indices each
    assign wr_rise = reg_wr && (reg_addr == pcint_pkg::OFS_RISE_A ||
                                reg_addr == pcint_pkg::OFS_RISE_B ||
                                reg_addr == pcint_pkg::OFS_RISE_C ||
                                reg_addr == pcint_pkg::OFS_RISE_E);
    assign wr_fall = reg_wr && (reg_addr == pcint_pkg::OFS_FALL_A ||
                                reg_addr == pcint_pkg::OFS_FALL_B ||
                                reg_addr == pcint_pkg::OFS_FALL_C ||
                                reg_addr == pcint_pkg::OFS_FALL_E);
    assign wr_flag = reg_wr && (reg_addr == pcint_pkg::OFS_FLAG_A ||
                                reg_addr == pcint_pkg::OFS_FLAG_B ||
                                reg_addr == pcint_pkg::OFS_FLAG_C ||
                                reg_addr == pcint_pkg::OFS_FLAG_E);
    assign wr_ctrl = reg_wr && (reg_addr == pcint_pkg::OFS_CTRL);
    assign wr_evt = reg_wr && (reg_addr == pcint_pkg::OFS_IRQ_ST);
    assign wr_msk = reg_wr && (reg_addr == pcint_pkg::OFS_IRQ_MSK);

    // read multiplexer, unmapped indices read zero
    function automatic logic [pcint_pkg::PORT_W-1:0] read_value(
        input pcint_st_t cur,
        input logic [3:0] addr
    );
        logic [pcint_pkg::PORT_W-1:0] res;
        logic [3:0] idx;
        res = pcint_pkg::BYTE_ZERO;
        idx = {2'h0, addr[1:0]};
        case (addr)
            pcint_pkg::OFS_RISE_A: begin
                res = get_byte(cur.rise_en, idx);
            end
            pcint_pkg::OFS_RISE_B: begin
                res = get_byte(cur.rise_en, idx);
            end
            pcint_pkg::OFS_RISE_C: begin
                res = get_byte(cur.rise_en, idx);
            end
            pcint_pkg::OFS_RISE_E: begin
                res = get_byte(cur.rise_en, idx);
            end
            pcint_pkg::OFS_FALL_A: begin
                res = get_byte(cur.fall_en, idx);
            end
            pcint_pkg::OFS_FALL_B: begin
                res = get_byte(cur.fall_en, idx);
            end
            pcint_pkg::OFS_FALL_C: begin
                res = get_byte(cur.fall_en, idx);
            end
            pcint_pkg::OFS_FALL_E: begin
                res = get_byte(cur.fall_en, idx);
            end
            pcint_pkg::OFS_FLAG_A: begin
                res = get_byte(cur.flags, idx);
            end
            pcint_pkg::OFS_FLAG_B: begin
                res = get_byte(cur.flags, idx);
            end
            pcint_pkg::OFS_FLAG_C: begin
                res = get_byte(cur.flags, idx);
            end
            pcint_pkg::OFS_FLAG_E: begin
                res = get_byte(cur.flags, idx);
            end
            pcint_pkg::OFS_CTRL: begin
                res[pcint_pkg::CTRL_MASTER_BIT] = cur.master_en;
                res[pcint_pkg::CTRL_SUMMARY_BIT] = cur.summary;
            end
            pcint_pkg::OFS_IRQ_ST: begin
                res[pcint_pkg::EVT_W-1:0] = cur.evt_st;
            end
            pcint_pkg::OFS_IRQ_MSK: begin
                res[pcint_pkg::EVT_W-1:0] = cur.evt_msk;
            end
            default: begin
                res = pcint_pkg::BYTE_ZERO;
            end
        endcase
        return res;
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.settle = {st_r.settle[pcint_pkg::SYNC_N-1:0], 1'b1};
        flags_wr = st_r.flags;
        // writing zero clears a flag; writing one keeps it
        if (wr_flag) begin
            flags_wr = put_byte(st_r.flags, sub,
                get_byte(st_r.flags, sub) & reg_wdata);
        end
        // a new edge wins over a clearing write
        flags_new = flags_wr | hit_ok;
        st_nxt.flags = flags_new;
        summary_new = |flags_new;
        st_nxt.summary = summary_new;
        if (wr_rise) begin
            st_nxt.rise_en = put_byte(st_r.rise_en, sub,
                                      reg_wdata);
        end
        if (wr_fall) begin
            st_nxt.fall_en = put_byte(st_r.fall_en, sub,
                                      reg_wdata);
        end
        if (wr_ctrl) begin
            st_nxt.master_en = reg_wdata[pcint_pkg::CTRL_MASTER_BIT];
        end
        if (wr_msk) begin
            st_nxt.evt_msk = reg_wdata[pcint_pkg::EVT_W-1:0];
        end
        // request gated by master enable
        st_nxt.chg_req = summary_new & st_nxt.master_en;
        // wake only after flags are already registered
        st_nxt.wake = st_r.summary & st_r.master_en
                      & core_asleep;
        // sticky event bits, set beats write-one clear
        evt = pcint_pkg::EVT_ZERO;
        evt[pcint_pkg::EVT_EDGE_BIT] = any_hit;
        evt[pcint_pkg::EVT_WAKE_BIT] = st_nxt.wake & ~st_r.wake;
        if (wr_evt) begin
            st_nxt.evt_st = (st_r.evt_st &
                ~reg_wdata[pcint_pkg::EVT_W-1:0]) | evt;
        end else begin
            st_nxt.evt_st = st_r.evt_st | evt;
        end
        st_nxt.irq = |(st_nxt.evt_st & st_nxt.evt_msk);
        // read data stand one cycle after the strobe only
        st_nxt.rdata = pcint_pkg::BYTE_ZERO;
        if (reg_rd) begin
            st_nxt.rdata = read_value(st_r, reg_addr);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign change_irq_summary_flag = st_r.summary;
    assign change_irq_req = st_r.chg_req;
    assign wake_req = st_r.wake;
    assign irq = st_r.irq;
endmodule
`default_nettype wire

// ### pcint_pkg.sv
// pcint_pkg: constants shared by the pin change interrupt design.
// assumes an 8-bit register port with one-cycle read latency.
package pcint_pkg;

    localparam int PORT_W = 8;
    // three full ports plus the single pin of the fifth port
    localparam int PIN_N = 25;
    localparam int SYNC_N = 2;
    localparam int ADDR_W = 4;

    localparam logic [3:0] OFS_RISE_A = 4'h0;
    localparam logic [3:0] OFS_RISE_B = 4'h1;
    localparam logic [3:0] OFS_RISE_C = 4'h2;
    localparam logic [3:0] OFS_RISE_E = 4'h3;
    localparam logic [3:0] OFS_FALL_A = 4'h4;
    localparam logic [3:0] OFS_FALL_B = 4'h5;
    localparam logic [3:0] OFS_FALL_C = 4'h6;
    localparam logic [3:0] OFS_FALL_E = 4'h7;
    localparam logic [3:0] OFS_FLAG_A = 4'h8;
    localparam logic [3:0] OFS_FLAG_B = 4'h9;
    localparam logic [3:0] OFS_FLAG_C = 4'ha;
    localparam logic [3:0] OFS_FLAG_E = 4'hb;
    localparam logic [3:0] OFS_CTRL = 4'hc;
    localparam logic [3:0] OFS_IRQ_ST = 4'hd;
    localparam logic [3:0] OFS_IRQ_MSK = 4'he;

    // bit of the fifth port that carries change detection
    localparam int PORT_E_BIT = 3;
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_SUMMARY_BIT = 1;
    localparam int EVT_EDGE_BIT = 0;
    localparam int EVT_WAKE_BIT = 1;
    localparam int EVT_W = 2;

    localparam logic [PIN_N-1:0] PIN_RST = 25'h0000000;
    localparam logic [PORT_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [EVT_W-1:0] EVT_ZERO = 2'h0;

endpackage

// ### pcint_edge.sv
// pcint_edge: synchroniser and two-way edge detector for one pin.
// assumes pin is an asynchronous level; rst_n is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module pcint_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and enables
    input wire logic pin,
    input wire logic rise_en,
    input wire logic fall_en,
    // detected enabled edge
    output logic edge_hit
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } pcint_edge_st_t;

    pcint_edge_st_t st_r;
    pcint_edge_st_t st_nxt;
    logic rising;
    logic falling;

    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = pin;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // compare two successive synchronised samples
    assign rising = st_r.sync & ~st_r.prev;
    assign falling = ~st_r.sync & st_r.prev;
    // either or both directions per pin
    assign edge_hit = (rising & rise_en) | (falling & fall_en);
endmodule
`default_nettype wire

// ### pcint_properties.sv
// pcint_properties: port-level checks of the pin change unit.
// assumes binding to pcint_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module pcint_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // pins and sleep
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_b_pins,
    input wire logic [7:0] port_c_pins,
    input wire logic port_e_pin_three,
    input wire logic core_asleep,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // requests
    input wire logic change_irq_summary_flag,
    input wire logic change_irq_req,
    input wire logic wake_req,
    input wire logic irq
);
    logic [24:0] pins_d_r;
    logic [24:0] pins_w;
    logic chg_w;
    assign pins_w = {port_e_pin_three, port_c_pins, port_b_pins, port_a_pins};
    assign chg_w = pins_w != pins_d_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_d_r <= 25'h0;
        end else begin
            pins_d_r <= pins_w;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_req_sum: assert property (
        change_irq_req |-> change_irq_summary_flag)
        else $error("request without summary");
    a_wake_order: assert property (
        $rose(wake_req) |-> $past(change_irq_req))
        else $error("wake before flags");
    a_wake_awake: assert property (
        !$past(core_asleep) |-> !wake_req)
        else $error("wake while awake");
    a_rd_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    a_rd_unmap: assert property (
        $past(reg_rd && reg_addr == 4'hf) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_edge_cause: assert property (
        $rose(change_irq_summary_flag) |->
        $past(chg_w, 3) || $past(chg_w, 4) || $past(chg_w, 5))
        else $error("flag without pin change");
    a_sum_holds: assert property (
        change_irq_summary_flag && !reg_wr && !$past(reg_wr)
        |=> change_irq_summary_flag)
        else $error("flag lost without write");
    a_fall_write: assert property (
        $fell(change_irq_summary_flag) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("summary fell without write");
    cover property (wake_req);
    cover property (change_irq_req);
    cover property (irq);
endmodule
bind pcint_top pcint_properties u_props (.core_clk, .arst_n, .port_a_pins,
    .port_b_pins, .port_c_pins, .port_e_pin_three, .core_asleep, .reg_addr,
    .reg_wr, .reg_rd, .reg_rdata, .change_irq_summary_flag, .change_irq_req,
    .wake_req, .irq);
`default_nettype wire

// ### pcint_pin_model.sv
// pcint_pin_model: outside signals on the monitored pins.
// assumes the bench calls put; levels hold two cycles at least.
`timescale 1ns/1ps
`default_nettype none
module pcint_pin_model (
    // clock
    input wire logic clk,
    // pins
    output logic [7:0] port_a_pins,
    output logic [7:0] port_b_pins,
    output logic [7:0] port_c_pins,
    output logic port_e_pin_three
);
    initial {port_e_pin_three, port_c_pins, port_b_pins, port_a_pins} = 25'h0;
    task automatic put(input logic [24:0] v);
        @(posedge clk);
        {port_e_pin_three, port_c_pins, port_b_pins, port_a_pins} <= v;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### tb_pin_change_interrupt.sv
// tb_pin_change_interrupt: register-driven tests of pcint_top.
// assumes pcint_pin_model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_pin_change_interrupt;
    logic core_clk, arst_n, core_asleep, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic change_irq_summary_flag, change_irq_req, wake_req, irq;
    logic [7:0] port_a_pins, port_b_pins, port_c_pins;
    logic port_e_pin_three;
    int mismatches, checks_done;
    pcint_pin_model u_pins (.clk(core_clk), .port_a_pins, .port_b_pins,
        .port_c_pins, .port_e_pin_three);
    pcint_top u_dut (.core_clk, .arst_n, .port_a_pins, .port_b_pins,
        .port_c_pins, .port_e_pin_three, .core_asleep, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .change_irq_summary_flag,
        .change_irq_req, .wake_req, .irq);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ob(input string nm, input logic e, input logic g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask
    task automatic hit(input logic [24:0] v);
        u_pins.put(v);
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {arst_n, core_asleep, reg_wr, reg_rd} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        mismatches = 0;
        checks_done = 0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        wr(4'hf, 8'h5a);
        rd(4'hf, 8'h00, "unmapped");
        rd(4'h0, 8'h00, "rise_en_a");
        wr(4'h3, 8'hff);
        rd(4'h3, 8'h08, "rise_en_e");
        $display("registers done");
        wr(4'h0, 8'h01);
        wr(4'hc, 8'h01);
        hit(25'h0000001);
        ob("summary", 1'b1, change_irq_summary_flag);
        ob("request", 1'b1, change_irq_req);
        wr(4'h8, 8'hfe);
        rd(4'h8, 8'h00, "flags_a");
        hit(25'h0000000);
        rd(4'h8, 8'h00, "flags_a");
        wr(4'h0, 8'h00);
        wr(4'h4, 8'h01);
        hit(25'h0000001);
        rd(4'h8, 8'h00, "flags_a");
        hit(25'h0000000);
        rd(4'h8, 8'h01, "flags_a");
        $display("single pin done");
        wr(4'h1, 8'h20);
        wr(4'h6, 8'h04);
        hit(25'h0ffff00);
        hit(25'h0000000);
        rd(4'h9, 8'h20, "flags_b");
        rd(4'ha, 8'h04, "flags_c");
        rd(4'h8, 8'h01, "flags_a");
        wr(4'h8, 8'h00);
        wr(4'h9, 8'h00);
        wr(4'ha, 8'h00);
        wr(4'h7, 8'h08);
        hit(25'h1000000);
        rd(4'hb, 8'h08, "flags_e");
        wr(4'hb, 8'h00);
        hit(25'h0000000);
        rd(4'hb, 8'h08, "flags_e");
        wr(4'hb, 8'h00);
        $display("multi pin done");
        wr(4'hc, 8'h00);
        hit(25'h1000000);
        ob("summary", 1'b1, change_irq_summary_flag);
        ob("request", 1'b0, change_irq_req);
        rd(4'hc, 8'h02, "control");
        wr(4'hb, 8'h00);
        u_pins.put(25'h0000000);
        // clear sampled at the very edge that registers the new edge
        reg_wr <= 1'b1;
        reg_addr <= 4'hb;
        reg_wdata <= 8'h00;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        rd(4'hb, 8'h08, "flags_e");
        wr(4'hb, 8'h00);
        $display("master and clear race done");
        wr(4'hc, 8'h01);
        wr(4'he, 8'h03);
        @(posedge core_clk);
        core_asleep <= 1'b1;
        hit(25'h1000000);
        repeat (2) @(posedge core_clk);
        #1;
        ob("wake", 1'b1, wake_req);
        ob("summary", 1'b1, change_irq_summary_flag);
        ob("irq", 1'b1, irq);
        rd(4'hd, 8'h03, "event_status");
        wr(4'he, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        ob("irq masked", 1'b0, irq);
        wr(4'hd, 8'h03);
        wr(4'he, 8'h03);
        @(posedge core_clk);
        core_asleep <= 1'b0;
        wr(4'hb, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        ob("irq cleared", 1'b0, irq);
        ob("wake", 1'b0, wake_req);
        $display("sleep and interrupt done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
